// ### rtl/spi_port_pkg.sv
// constants used by the serial port
package spi_port_pkg;
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam logic [3:0] LAST_HALF = 4'hf;
	localparam logic [3:0] SCK_RISES = 4'h8;
	localparam logic [1:0] SEL_THREE_WIRE = 2'h0;
	localparam logic [1:0] SEL_MULTI = 2'h1;
	localparam logic [1:0] SEL_RESET = 2'h1;
	localparam int CTL_DONE = 7;
	localparam int CTL_MASTER = 6;
	localparam int CTL_MODE_FAULT_FLAG = 5;
	localparam int CTL_OVR = 4;
	localparam int CTL_SEL_HIGH = 3;
	localparam int CTL_SEL_LOW = 2;
	localparam int CTL_WRITE_COLLISION_FLAG = 1;
	localparam int CTL_ENABLE = 0;
endpackage : spi_port_pkg

// ### rtl/sync_ff.sv
// two flip-flop level synchroniser
module sync_ff #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] q;
	} sync_s;
	sync_s st;
	sync_s next_st;

	always_comb begin
		next_st.meta = d;
		next_st.q = st.meta;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign q = st.q;
endmodule : sync_ff

// ### rtl/flag_bit.sv
// sticky status flag, a set in the clearing cycle wins
module flag_bit (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic set,
	input wire logic clear,
	output logic flag
);
	logic next_flag;

	always_comb begin
		next_flag = flag;
		if (clear) begin
			next_flag = 1'b0;
		end
		if (set) begin
			next_flag = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flag <= 1'b0;
		end else begin
			flag <= next_flag;
		end
	end
endmodule : flag_bit

// ### rtl/spi_port.sv
// full-duplex serial port, master or slave, 3-wire or 4-wire
// Operation
// [R1] master drives mosi from shift register msb; slave takes mosi as input
// [R2] miso is released while disabled or while an unselected 4-wire slave
// [R3] 3-wire slave always drives miso from shift register msb
// [R4] unselected 4-wire slave ignores every serial clock edge
// [R5] select mode 00 is 3-wire, slave always selected, only slave on bus
// [R6] select mode 01: select input; falling select stops a master
// [R7] select mode 1x drives select out at the lower mode bit
// [R8] select routed to a pin except in 3-wire settings
// [R9] master enable bit chooses master, otherwise enabled port is slave
// [R10] master data write fills buffer; empty shifter loads and starts transfer
// [R11] master shifts byte out at once while making the serial clock
// [R12] transfer end sets done flag, which may raise an interrupt
// [R13] master shifts miso in msb first, byte goes to receive buffer
// [R14] multi-master select low clears enables, sets mode fault until rewritten
// [R15] select mode at bits 3 and 2, reset value 01
// [R16] slave counts clock edges, after eight sets done and stores byte
// [R17] 4-wire slave bit counter reset by select going high
// [R18] data write while buffer full is dropped and sets collision flag
// [R19] slave byte arriving on unread buffer sets overrun, old byte kept
// [R20] master clock from divider, exactly eight clock cycles per byte
module spi_port
	import spi_port_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sck_link,
	input wire logic ctl_write,
	input wire logic ctl_master_enable,
	input wire logic ctl_block_enable,
	input wire logic [1:0] ctl_select_mode,
	input wire logic int_enable,
	input wire logic [7:0] clk_div,
	input wire logic clr_done,
	input wire logic clr_write_collision_flag,
	input wire logic clr_mode_fault_flag,
	input wire logic clr_ovr,
	input wire logic data_write,
	input wire logic [7:0] data_wdata,
	input wire logic data_read,
	input wire logic mosi_in,
	output logic mosi_out,
	output logic mosi_oe,
	input wire logic miso_in,
	output logic miso_out,
	output logic miso_oe,
	output logic sck_out,
	output logic sck_oe,
	input wire logic nss_in,
	output logic nss_out,
	output logic nss_oe,
	output logic nss_routed,
	output logic master_enable_bit,
	output logic block_enable_bit,
	output logic [1:0] select_mode,
	output logic transfer_done_flag,
	output logic write_collision_flag,
	output logic mode_fault_flag,
	output logic receive_overrun_flag,
	output logic [7:0] control_register,
	output logic [7:0] rx_data,
	output logic busy,
	output logic irq
);
	// ************************************************************
	// system clock state
	// ************************************************************
	typedef struct packed {
		logic master_en;
		logic enable;
		logic [1:0] sel;
		logic [7:0] tx_buf;
		logic tx_full;
		logic tx_req;
		logic [7:0] shreg;
		logic sample;
		logic busy;
		logic [3:0] half;
		logic [7:0] div;
		logic sck;
		logic [7:0] rx_buf;
		logic rx_full;
		logic done_seen;
		logic nss_prev;
		logic mosi_oe;
		logic miso_oe;
		logic sck_oe;
		logic nss_out;
		logic nss_oe;
		logic nss_routed;
		logic [7:0] ctl;
		logic irq;
	} core_s;

	typedef struct packed {
		logic [7:0] shreg;
		logic [7:0] rx_word;
		logic done_tgl;
		logic ack_tgl;
	} link_s;

	core_s c;
	core_s next_c;
	link_s lk;
	link_s next_lk;
	logic [2:0] link_cnt;
	logic [2:0] next_link_cnt;
	logic miso_s;
	logic nss_s;
	logic done_s;
	logic ack_s;
	logic req_s;
	logic link_rst_n;
	logic set_done;
	logic set_write_collision_flag;
	logic set_mode_fault_flag;
	logic set_ovr;
	logic master_done;
	logic slave_done;
	logic nss_fall;

	sync_ff #(.W(4)) core_sync (
		.clk(clk),
		.rst_n(rst_n),
		.d({miso_in, nss_in, lk.done_tgl, lk.ack_tgl}),
		.q({miso_s, nss_s, done_s, ack_s})
	);

	sync_ff #(.W(1)) link_sync (
		.clk(sck_link),
		.rst_n(rst_n),
		.d(c.tx_req),
		.q(req_s)
	);

	flag_bit done_flag (.clk(clk), .rst_n(rst_n), .set(set_done), .clear(clr_done),
		.flag(transfer_done_flag));
	flag_bit write_collision_flag_flag (.clk(clk), .rst_n(rst_n), .set(set_write_collision_flag), .clear(clr_write_collision_flag),
		.flag(write_collision_flag));
	flag_bit mode_fault_flag_flag (.clk(clk), .rst_n(rst_n), .set(set_mode_fault_flag), .clear(clr_mode_fault_flag),
		.flag(mode_fault_flag));
	flag_bit ovr_flag (.clk(clk), .rst_n(rst_n), .set(set_ovr), .clear(clr_ovr),
		.flag(receive_overrun_flag));

	assign nss_fall = c.nss_prev & ~nss_s;
	assign slave_done = done_s != c.done_seen;

	always_comb begin
		next_c = c;
		set_write_collision_flag = 1'b0;
		set_mode_fault_flag = 1'b0;
		set_ovr = 1'b0;
		master_done = 1'b0;
		next_c.nss_prev = nss_s;
		next_c.done_seen = done_s;
		if (ctl_write) begin
			next_c.master_en = ctl_master_enable;
			next_c.enable = ctl_block_enable;
			next_c.sel = ctl_select_mode;
		end
		// slave buffer drained once the link acknowledges the load
		if (!c.master_en && c.tx_full && c.tx_req == ack_s) begin
			next_c.tx_full = 1'b0;
		end
		if (data_read) begin
			next_c.rx_full = 1'b0;
		end
		// [R18] collision drops the write
		if (data_write && c.tx_full) begin
			set_write_collision_flag = 1'b1;
		end else if (data_write) begin
			next_c.tx_buf = data_wdata;
			next_c.tx_full = 1'b1;
			if (!c.master_en) begin
				next_c.tx_req = ~c.tx_req;
			end
		end
		// [R10] start when the shifter is free
		if (c.master_en && c.enable && !c.busy && c.tx_full) begin
			next_c.shreg = c.tx_buf;
			next_c.tx_full = 1'b0;
			next_c.busy = 1'b1;
			next_c.half = '0;
			next_c.div = '0;
		end
		// [R20] divider sets each half period to clk_div+1 cycles
		if (c.busy) begin
			if (c.div == clk_div) begin
				next_c.div = '0;
				next_c.sck = ~c.sck;
				next_c.half = c.half + 4'h1;
				if (!c.sck) begin
					next_c.sample = miso_s;
				end else begin
					// [R13] msb first into the shifter
					next_c.shreg = {c.shreg[6:0], c.sample};
				end
				if (c.half == LAST_HALF) begin
					master_done = 1'b1;
					next_c.busy = 1'b0;
					next_c.rx_buf = {c.shreg[6:0], c.sample};
					next_c.rx_full = 1'b1;
				end
			end else begin
				next_c.div = c.div + 8'h01;
			end
		end
		// [R19] overrun keeps the unread byte
		if (slave_done && !c.master_en) begin
			if (c.rx_full && !data_read) begin
				set_ovr = 1'b1;
			end else begin
				next_c.rx_buf = lk.rx_word;
				next_c.rx_full = 1'b1;
			end
		end
		// [R6] [R14] falling select takes the master off the bus
		if (c.master_en && c.enable && c.sel == SEL_MULTI && nss_fall) begin
			set_mode_fault_flag = 1'b1;
			next_c.master_en = 1'b0;
			next_c.enable = 1'b0;
		end
		if (!next_c.enable || !next_c.master_en) begin
			next_c.busy = 1'b0;
			next_c.sck = 1'b0;
		end
		// [R9] role from the master enable bit
		next_c.mosi_oe = next_c.enable & next_c.master_en;
		next_c.sck_oe = next_c.enable & next_c.master_en;
		// [R2] released when disabled or unselected
		next_c.miso_oe = next_c.enable & ~next_c.master_en &
			(next_c.sel == SEL_THREE_WIRE || (next_c.sel == SEL_MULTI && !nss_s));
		// [R7] select as output follows the lower mode bit
		next_c.nss_oe = next_c.enable & next_c.sel[1];
		next_c.nss_out = next_c.sel[0];
		// [R8] no select pin in the 3-wire settings
		next_c.nss_routed = next_c.sel != SEL_THREE_WIRE;
		// flag bits lag their flops by one cycle here
		next_c.ctl = '0;
		next_c.ctl[CTL_DONE] = transfer_done_flag;
		next_c.ctl[CTL_MASTER] = next_c.master_en;
		next_c.ctl[CTL_MODE_FAULT_FLAG] = mode_fault_flag;
		next_c.ctl[CTL_OVR] = receive_overrun_flag;
		next_c.ctl[CTL_SEL_HIGH] = next_c.sel[1];
		next_c.ctl[CTL_SEL_LOW] = next_c.sel[0];
		next_c.ctl[CTL_WRITE_COLLISION_FLAG] = write_collision_flag;
		next_c.ctl[CTL_ENABLE] = next_c.enable;
		next_c.irq = int_enable & (transfer_done_flag | write_collision_flag |
			mode_fault_flag | receive_overrun_flag);
	end

	// [R12] both master and slave byte ends raise the done flag
	assign set_done = master_done | (slave_done & ~c.master_en);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			c <= '0;
			c.sel <= SEL_RESET;
			// mode field shows its reset value from the first cycle
			c.ctl[CTL_SEL_LOW] <= 1'b1;
			c.nss_prev <= 1'b1;
			c.nss_routed <= 1'b1;
			c.nss_out <= 1'b1;
		end else begin
			c <= next_c;
		end
	end

	// ************************************************************
	// link clock logic, slave side
	// ************************************************************
	// [R4] [R17] select high holds the bit counter in reset
	// [R5] the 3-wire slave is always selected
	assign link_rst_n = rst_n & c.enable & ~c.master_en &
		~(c.sel == SEL_MULTI & nss_in);

	always_comb begin
		next_lk = lk;
		next_link_cnt = link_cnt + 3'h1;
		// [R1] slave takes mosi in, msb first
		next_lk.shreg = {lk.shreg[6:0], mosi_in};
		// [R16] eighth edge completes the byte
		if (link_cnt == LAST_BIT) begin
			next_lk.rx_word = next_lk.shreg;
			next_lk.done_tgl = ~lk.done_tgl;
			// tx_buf is held steady until the ack returns
			if (req_s != lk.ack_tgl) begin
				next_lk.shreg = c.tx_buf;
				next_lk.ack_tgl = ~lk.ack_tgl;
			end
		end
	end

	always_ff @(posedge sck_link or negedge link_rst_n) begin
		if (!link_rst_n) begin
			link_cnt <= '0;
		end else begin
			link_cnt <= next_link_cnt;
		end
	end

	always_ff @(posedge sck_link or negedge rst_n) begin
		if (!rst_n) begin
			lk <= '0;
		end else if (link_rst_n) begin
			lk <= next_lk;
		end
	end

	// [R1] [R11] master drives mosi and sck from its own flops
	assign mosi_out = c.shreg[7];
	assign sck_out = c.sck;
	assign mosi_oe = c.mosi_oe;
	assign sck_oe = c.sck_oe;
	// [R3] slave shifter msb on miso
	assign miso_out = lk.shreg[7];
	assign miso_oe = c.miso_oe;
	assign nss_out = c.nss_out;
	assign nss_oe = c.nss_oe;
	assign nss_routed = c.nss_routed;
	assign master_enable_bit = c.master_en;
	assign block_enable_bit = c.enable;
	// [R15] mode field reset value 01
	assign select_mode = c.sel;
	assign control_register = c.ctl;
	assign rx_data = c.rx_buf;
	assign busy = c.busy;
	assign irq = c.irq;

	// ************************************************************
	// assertions
	// ************************************************************
	logic [3:0] rise_cnt;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rise_cnt <= '0;
		end else if (!c.busy) begin
			rise_cnt <= '0;
		end else if (next_c.sck && !c.sck) begin
			rise_cnt <= rise_cnt + 4'h1;
		end
	end

	default clocking dc @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence start_req;
		data_write && !c.tx_full && c.master_en && c.enable && !c.busy && !ctl_write;
	endsequence
	sequence fault_cond;
		c.master_en && c.enable && c.sel == SEL_MULTI && nss_fall;
	endsequence

	a_miso_release: assert property (!c.enable |-> !miso_oe) // [R2]
		else $error("miso driven while disabled");
	a_three_wire_drive: assert property (c.enable && !c.master_en && // [R3]
		c.sel == SEL_THREE_WIRE |-> miso_oe && !mosi_oe)
		else $error("3-wire slave not driving miso");
	a_select_output: assert property (c.enable && c.sel[1] |-> // [R7]
		nss_oe && nss_out == c.sel[0])
		else $error("select output wrong");
	a_select_routing: assert property (nss_routed == (c.sel != SEL_THREE_WIRE)) // [R8]
		else $error("select routing wrong");
	a_master_start: assert property (start_req ##1 !nss_fall |=> c.busy) // [R10]
		else $error("master transfer did not start");
	a_mode_fault: assert property (fault_cond |=> // [R14]
		!c.master_en && !c.enable && mode_fault_flag)
		else $error("mode fault not taken");
	a_eight_clocks: assert property (master_done |-> rise_cnt == SCK_RISES) // [R20]
		else $error("master byte without eight clocks");
	a_done_flag: assert property (master_done |=> transfer_done_flag && c.rx_full) // [R12]
		else $error("done flag not set");
	a_write_collision: assert property (data_write && c.tx_full |=> // [R18]
		write_collision_flag && c.tx_buf == $past(c.tx_buf))
		else $error("collision write not dropped");
	a_rx_overrun: assert property (slave_done && !c.master_en && c.rx_full && // [R19]
		!data_read |=> receive_overrun_flag && $stable(c.rx_buf))
		else $error("overrun not flagged");
endmodule : spi_port

// ### testbench/far_end.sv
// far-side model: slave to the port as master, master to the port as slave
module far_end (
	input wire logic sck_out,
	input wire logic mosi_out,
	input wire logic miso_out,
	output logic miso_in,
	output logic mosi_in,
	output logic sck_link,
	output logic nss_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] sreg;
	logic [7:0] cap;
	logic [3:0] rises;
	logic [7:0] mcap;
	initial begin
		mcap = 8'h00;
		sreg = 8'h00;
		cap = 8'h00;
		rises = 4'h0;
		mosi_in = 1'b0;
		sck_link = 1'b0;
		nss_in = 1'b1;
	end
	assign miso_in = sreg[7];
	always @(posedge sck_out) begin
		cap = {cap[6:0], mosi_out};
		rises = rises + 4'h1;
	end
	// far master takes miso as it stands at each rising link clock
	always @(posedge sck_link) mcap = {mcap[6:0], miso_out};
	// shift on the fall so miso holds a whole half period past the sampling rise
	always @(negedge sck_out) sreg = {sreg[6:0], ~sreg[7]};
	task load(input logic [7:0] b);
		sreg = b;
		cap = 8'h00;
		rises = 4'h0;
	endtask : load
	task send(input logic [7:0] b, input logic sel);
		integer i;
		mcap = 8'h00;
		nss_in = ~sel;
		#43;
		for (i = 0; i < 8; i++) begin
			mosi_in = b[7-i];
			#32 sck_link = 1'b1;
			#32 sck_link = 1'b0;
		end
		#32 nss_in = 1'b1;
		// released line: inverse of last value, clock stands still
		mosi_in = ~mosi_in;
	endtask : send
endmodule : far_end

// ### testbench/spi_master_slave_port_test.sv
// self-checking bench for the serial port against the far-side model
module spi_master_slave_port_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_n, ctl_write, ctl_master_enable, ctl_block_enable, int_enable;
	logic clr_done, clr_write_collision_flag, clr_mode_fault_flag, clr_ovr, data_write, data_read;
	logic [1:0] ctl_select_mode, select_mode;
	logic [7:0] clk_div, data_wdata, control_register, rx_data, b1;
	logic sck_link, mosi_in, miso_in, nss_in, mosi_out, mosi_oe, miso_out, miso_oe;
	logic sck_out, sck_oe, nss_out, nss_oe, nss_routed, master_enable_bit, block_enable_bit;
	logic transfer_done_flag, write_collision_flag, mode_fault_flag, receive_overrun_flag;
	logic busy, irq;
	logic [7:0] exp_q[$];
	integer error_cnt = 0;
	integer n_tests = 0;
	integer seed = 77;
	integer k;
	spi_port uut (.clk(clk), .rst_n(rst_n), .sck_link(sck_link), .ctl_write(ctl_write),
		.ctl_master_enable(ctl_master_enable), .ctl_block_enable(ctl_block_enable),
		.ctl_select_mode(ctl_select_mode), .int_enable(int_enable), .clk_div(clk_div),
		.clr_done(clr_done), .clr_write_collision_flag(clr_write_collision_flag), .clr_mode_fault_flag(clr_mode_fault_flag), .clr_ovr(clr_ovr),
		.data_write(data_write), .data_wdata(data_wdata), .data_read(data_read),
		.mosi_in(mosi_in), .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_in),
		.miso_out(miso_out), .miso_oe(miso_oe), .sck_out(sck_out), .sck_oe(sck_oe),
		.nss_in(nss_in), .nss_out(nss_out), .nss_oe(nss_oe), .nss_routed(nss_routed),
		.master_enable_bit(master_enable_bit), .block_enable_bit(block_enable_bit),
		.select_mode(select_mode), .transfer_done_flag(transfer_done_flag),
		.write_collision_flag(write_collision_flag), .mode_fault_flag(mode_fault_flag),
		.receive_overrun_flag(receive_overrun_flag), .control_register(control_register),
		.rx_data(rx_data), .busy(busy), .irq(irq));
	far_end fe (.sck_out(sck_out), .mosi_out(mosi_out), .miso_out(miso_out),
		.miso_in(miso_in), .mosi_in(mosi_in), .sck_link(sck_link), .nss_in(nss_in));
	always #4 clk = ~clk;
	task chk(input logic [7:0] got, input logic [7:0] want);
		n_tests = n_tests + 1;
		if (got !== want) begin
			error_cnt = error_cnt + 1;
			$display("Error at %0t: got %h expected %h", $time, got, want);
		end
	endtask : chk
	task wrap_up;
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : wrap_up
	task ctl(input logic m, input logic e, input logic [1:0] md);
		@(negedge clk);
		ctl_master_enable = m;
		ctl_block_enable = e;
		ctl_select_mode = md;
		ctl_write = 1'b1;
		@(negedge clk);
		ctl_write = 1'b0;
	endtask : ctl
	task clr(input logic rd);
		@(negedge clk);
		{clr_done, clr_write_collision_flag, clr_mode_fault_flag, clr_ovr, data_read} = {4'hf, rd};
		@(negedge clk);
		{clr_done, clr_write_collision_flag, clr_mode_fault_flag, clr_ovr, data_read} = 5'h00;
	endtask : clr
	task mxfer(input logic [7:0] tx, input logic [7:0] rxv, input logic collide);
		integer i;
		fe.load(rxv);
		exp_q.push_back(rxv);
		@(negedge clk);
		data_wdata = tx;
		data_write = 1'b1;
		@(negedge clk);
		data_wdata = ~tx;
		data_write = collide;
		@(negedge clk);
		data_write = 1'b0;
		chk({6'h0, busy, mosi_oe & sck_oe}, 8'h03);
		for (i = 0; i < 600 && transfer_done_flag !== 1'b1; i++) @(negedge clk);
		chk({7'h0, busy}, 8'h00);
		chk(fe.cap, tx);
		chk({4'h0, fe.rises}, 8'h08);
		chk({7'h0, write_collision_flag}, {7'h0, collide});
		clr(1'b1);
	endtask : mxfer
	// ***********
	// result watcher
	// ***********
	always @(posedge transfer_done_flag) begin
		@(negedge clk);
		if (exp_q.size() == 0) chk(8'h00, 8'h01);
		else chk(rx_data, exp_q.pop_front());
	end
	initial begin
		#100000;
		$display("Error at %0t: timeout", $time);
		error_cnt = error_cnt + 1;
		wrap_up();
	end
	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		{ctl_write, ctl_master_enable, ctl_block_enable, ctl_select_mode} = 5'h00;
		{clr_done, clr_write_collision_flag, clr_mode_fault_flag, clr_ovr, data_write, data_read} = 6'h00;
		int_enable = 1'b1;
		clk_div = 8'h00;
		data_wdata = 8'h00;
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		chk(control_register, 8'h04);
		chk({6'h0, miso_oe, nss_routed}, 8'h01);
		ctl(1'b1, 1'b1, 2'b00);
		chk({6'h0, master_enable_bit, nss_routed}, 8'h02);
		for (k = 0; k < 4; k++) begin
			// miso crosses two flops, so a half period needs three clocks at least
			clk_div = 8'h02 + (8'($random(seed)) & 8'h03);
			mxfer(8'($random(seed)), 8'($random(seed)), k[0]);
		end
		ctl(1'b1, 1'b1, 2'b11);
		chk({5'h0, nss_out, nss_oe, nss_routed}, 8'h07);
		ctl(1'b1, 1'b1, 2'b10);
		chk({5'h0, nss_out, nss_oe, nss_routed}, 8'h03);
		ctl(1'b1, 1'b1, 2'b01);
		fe.nss_in = 1'b0;
		repeat (6) @(negedge clk);
		chk({4'h0, master_enable_bit, block_enable_bit, mode_fault_flag, irq}, 8'h03);
		fe.nss_in = 1'b1;
		clr(1'b1);
		ctl(1'b0, 1'b1, 2'b01);
		chk({5'h0, miso_oe, mosi_oe, sck_oe}, 8'h00);
		b1 = 8'($random(seed));
		exp_q.push_back(b1);
		fe.send(b1, 1'b1);
		repeat (8) @(negedge clk);
		clr(1'b0);
		fe.send(8'h5a, 1'b0);
		repeat (8) @(negedge clk);
		chk({7'h0, transfer_done_flag}, 8'h00);
		exp_q.push_back(b1);
		fe.send(~b1, 1'b1);
		repeat (8) @(negedge clk);
		chk({7'h0, receive_overrun_flag}, 8'h01);
		clr(1'b1);
		ctl(1'b0, 1'b1, 2'b00);
		chk({7'h0, miso_oe}, 8'h01);
		b1 = 8'($random(seed));
		exp_q.push_back(b1);
		@(negedge clk);
		data_wdata = ~b1;
		data_write = 1'b1;
		@(negedge clk);
		data_write = 1'b0;
		fe.send(b1, 1'b0);
		repeat (8) @(negedge clk);
		clr(1'b1);
		exp_q.push_back(~b1);
		fe.send(~b1, 1'b0);
		repeat (8) @(negedge clk);
		chk(fe.mcap, ~b1);
		chk(8'(exp_q.size()), 8'h00);
		wrap_up();
	end
endmodule : spi_master_slave_port_test
